// ### hdl/tmv_timer.sv
// eight-bit event timer with two compare constants and waveform pin
//
// Functional notes
// - eight-bit counter counts up on selected source
// - counter readable and writable at any time
// - wrap past maximum sets wrap flag
// - reset loads counter with zero
// - compare constants reset to all ones, writable
// - counter equal constant A sets flag A
// - constant B behaves like constant A
// - flag A with enable requests interrupt
// - no compare A during write to it
// - waveform pin follows matches and action bits
// - control zero bits 7:5 enable interrupts
// - clear select 00 none, 01 A, 10 B
// - code 11 clears on clear pin rise
// - counter can halt when cleared
// - select codes 000 and 100 block counting
// - internal codes count divided clock falling edges
// - external codes count rise, fall or both
// - trigger edge rise, fall or both starts count
// - flags cleared by write 0 after read 1
// - action codes keep, low, high, toggle per match
// - waveform pin low until first match
// - trigger start halts on clearing match
//
// Our own choices: the register offsets and the strobed register port.
`default_nettype none
module tmv_timer
  import tmv_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [TMV_AW-1:0] addr_i,
  input wire logic [TMV_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [TMV_DW-1:0] rdata_o,
  input wire logic ext_count_clock_pin_i,
  input wire logic ext_clear_pin_i,
  input wire logic start_trigger_pin_i,
  output logic wave_out_pin_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////
  // helpers

  // edge hit for a select code: bit 0 rise, bit 1 fall
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    edge_hit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
  endfunction

  // new pin level for a match action
  function automatic logic apply_act(input tmv_act_t act, input logic cur);
    unique case (act)
      ACT_KEEP: apply_act = cur;
      ACT_LOW: apply_act = 1'b0;
      ACT_HIGH: apply_act = 1'b1;
      ACT_TOGGLE: apply_act = ~cur;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] cnt_q;
  logic [7:0] cora_q;
  logic [7:0] corb_q;
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [3:0] act_q;
  logic [2:0] flag_q;
  logic [2:0] arm_q;
  logic [6:0] pre_q;
  logic [2:0] xclk_q;
  logic [2:0] xclr_q;
  logic [2:0] trig_q;
  logic eq_a_q;
  logic eq_b_q;
  tmv_run_t run_q;
  logic [7:0] rdata_q;
  logic wave_q;
  logic irq_q;

  logic wr_cnt;
  logic wr_cora;
  logic wr_corb;
  logic wr_csr;
  logic eq_a;
  logic eq_b;
  logic mev_a;
  logic mev_b;
  logic [2:0] cks;
  logic [2:0] div_log;
  logic [6:0] div_mask;
  logic src_tick;
  logic cnt_tick;
  logic clr_ev;
  logic wrap_ev;
  logic trig_ev;
  tmv_clr_t clr_sel;
  logic [7:0] csr_view;

  ////////////////////////////////////////////////////////////////
  // register port decode

  assign wr_cnt = wr_i & (addr_i == OFS_CNT);
  assign wr_cora = wr_i & (addr_i == OFS_CORA);
  assign wr_corb = wr_i & (addr_i == OFS_CORB);
  assign wr_csr = wr_i & (addr_i == OFS_CSR);
  assign clr_sel = tmv_clr_t'(ctl0_q[C0_CLR_HI:C0_CLR_LO]);
  assign cks = ctl0_q[C0_CKS_HI:C0_CKS_LO];
  assign csr_view = {flag_q, 1'b0, act_q} | CS_ONES;

  // control and constant registers
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cora_q <= COR_RST;
      corb_q <= COR_RST;
      ctl0_q <= CTL_RST;
      ctl1_q <= CTL_RST;
      act_q <= 4'h0;
    end else if (ce_i && wr_i) begin
      unique case (addr_i)
        OFS_CORA: cora_q <= wdata_i;
        OFS_CORB: corb_q <= wdata_i;
        OFS_CTL0: ctl0_q <= wdata_i;
        OFS_CTL1: ctl1_q <= wdata_i & ~C1_ONES;
        OFS_CSR: act_q <= wdata_i[CS_ACT_B_HI:CS_ACT_A_LO];
        default: ;
      endcase
    end
  end

  // read data, valid one cycle after the strobe only
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= RD_IDLE;
    end else if (ce_i) begin
      rdata_q <= RD_IDLE;
      if (rd_i) begin
        unique case (addr_i)
          OFS_CNT: rdata_q <= cnt_q;
          OFS_CORA: rdata_q <= cora_q;
          OFS_CORB: rdata_q <= corb_q;
          OFS_CTL0: rdata_q <= ctl0_q;
          OFS_CSR: rdata_q <= csr_view;
          OFS_CTL1: rdata_q <= ctl1_q | C1_ONES;
          default: rdata_q <= RD_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin synchronisers, stage 0 feeds stage 1 only

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      xclk_q <= 3'h0;
      xclr_q <= 3'h0;
      trig_q <= 3'h0;
    end else if (ce_i) begin
      xclk_q <= {xclk_q[1:0], ext_count_clock_pin_i};
      xclr_q <= {xclr_q[1:0], ext_clear_pin_i};
      trig_q <= {trig_q[1:0], start_trigger_pin_i};
    end
  end

  ////////////////////////////////////////////////////////////////
  // count source selection

  // free prescaler; bit k-1 falls when the low k bits are all ones
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pre_q <= PRE_RST;
    end else if (ce_i) begin
      pre_q <= pre_q + 7'h01;
    end
  end

  assign div_log = {cks[1:0], ctl1_q[C1_PICK]};
  assign div_mask = 7'((8'h01 << div_log) - 8'h01);

  // internal divided tick, external edges, or nothing
  always_comb begin
    src_tick = 1'b0;
    if (cks[1:0] != 2'b00) begin
      if (!cks[2]) begin
        src_tick = &(pre_q | ~div_mask);
      end else begin
        src_tick = edge_hit(cks[1:0], xclk_q[2], xclk_q[1]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // compare, clear and trigger events

  assign eq_a = (cnt_q == cora_q) & ~wr_cora;
  assign eq_b = (cnt_q == corb_q) & ~wr_corb;
  assign mev_a = eq_a & ~eq_a_q;
  assign mev_b = eq_b & ~eq_b_q;
  assign trig_ev = edge_hit(ctl1_q[C1_EDGE_HI:C1_EDGE_LO], trig_q[2], trig_q[1]);

  // clear condition chosen by the clear select field
  always_comb begin
    unique case (clr_sel)
      CLR_NONE: clr_ev = 1'b0;
      CLR_MATCH_A: clr_ev = mev_a;
      CLR_MATCH_B: clr_ev = mev_b;
      CLR_PIN: clr_ev = edge_hit(EDGE_RISE, xclr_q[2], xclr_q[1]);
    endcase
  end

  assign cnt_tick = src_tick & (run_q == ST_RUN);
  assign wrap_ev = cnt_tick & (cnt_q == CNT_MAX) & ~clr_ev & ~wr_cnt;

  // match history so a standing match fires once
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      eq_a_q <= 1'b0;
      eq_b_q <= 1'b0;
    end else if (ce_i) begin
      eq_a_q <= eq_a;
      eq_b_q <= eq_b;
    end
  end

  // count gate: trigger starts, a clear halts
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      run_q <= ST_RUN;
    end else if (ce_i) begin
      if (!ctl1_q[C1_TRIGGER_START_ENABLE]) begin
        run_q <= ST_RUN;
      end else if (clr_ev) begin
        run_q <= ST_HALT;
      end else if (trig_ev) begin
        run_q <= ST_RUN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // counter

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= CNT_RST;
    end else if (ce_i) begin
      if (wr_cnt) begin
        cnt_q <= wdata_i;
      end else if (clr_ev) begin
        cnt_q <= CNT_RST;
      end else if (cnt_tick) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // flags: set beats clear, clear needs a prior read of one

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      flag_q <= 3'h0;
      arm_q <= 3'h0;
    end else if (ce_i) begin
      if (wr_csr) begin
        arm_q <= 3'h0;
      end else if (rd_i && addr_i == OFS_CSR) begin
        arm_q <= arm_q | flag_q;
      end
      flag_q[2] <= mev_b | (flag_q[2] & ~(wr_csr & arm_q[2] & ~wdata_i[CS_FLAG_B]));
      flag_q[1] <= mev_a | (flag_q[1] & ~(wr_csr & arm_q[1] & ~wdata_i[CS_FLAG_A]));
      flag_q[0] <= wrap_ev | (flag_q[0] & ~(wr_csr & arm_q[0] & ~wdata_i[CS_FLAG_W]));
    end
  end

  ////////////////////////////////////////////////////////////////
  // waveform pin and interrupt request

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wave_q <= 1'b0;
    end else if (ce_i) begin
      if (mev_b) begin
        wave_q <= apply_act(tmv_act_t'(act_q[3:2]), mev_a ? apply_act(tmv_act_t'(act_q[1:0]), wave_q) : wave_q);
      end else if (mev_a) begin
        wave_q <= apply_act(tmv_act_t'(act_q[1:0]), wave_q);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= |(flag_q & ctl0_q[C0_IE_B:C0_IE_W]);
    end
  end

  assign rdata_o = rdata_q;
  assign wave_out_pin_o = wave_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_write_wins: assert property (ce_i && wr_cnt ##1 ce_i |-> cnt_q == $past(wdata_i))
    else $error("counter write lost");
  a_wrap_flag: assert property (ce_i && wrap_ev |=> flag_q[0])
    else $error("wrap flag not set");
  a_match_a_flag: assert property (ce_i && mev_a |=> flag_q[1])
    else $error("flag a not set");
  a_match_b_flag: assert property (ce_i && mev_b |=> flag_q[2])
    else $error("flag b not set");
  a_irq_a: assert property (ce_i && flag_q[1] && ctl0_q[C0_IE_A] |=> irq_o)
    else $error("interrupt a missing");
  a_suppress_a: assert property (ce_i && wr_cora |-> !mev_a)
    else $error("match a during constant write");
  a_no_cmp_write: assert property (ce_i && wr_cora && !flag_q[1] |=> !flag_q[1])
    else $error("compare during constant write");
  a_clear_a: assert property (ce_i && clr_sel == CLR_MATCH_A && mev_a && !wr_cnt |=> cnt_q == CNT_RST)
    else $error("clear on match a missing");
  a_halt_trig: assert property (ce_i && ctl1_q[C1_TRIGGER_START_ENABLE] && clr_ev |=> run_q == ST_HALT)
    else $error("no halt after clear");
  a_out_high: assert property (ce_i && mev_a && !mev_b && act_q[1:0] == ACT_HIGH |=> wave_out_pin_o)
    else $error("pin not driven high");
  a_no_count_off: assert property (ce_i && cks[1:0] == 2'b00 && !wr_cnt && !clr_ev |=> $stable(cnt_q))
    else $error("count while blocked");

  c_wrap: cover property (ce_i && wrap_ev);
  c_pin_clear: cover property (ce_i && clr_sel == CLR_PIN && clr_ev);
  c_trig_start: cover property (run_q == ST_HALT ##1 run_q == ST_RUN);
  c_toggle: cover property (ce_i && mev_b && act_q[3:2] == ACT_TOGGLE);

endmodule
`default_nettype wire

// ### pkg/tmv_pkg.sv
// constants, field layout and types of the eight-bit event timer
`default_nettype none
package tmv_pkg;
  // register port widths
  localparam int unsigned TMV_AW = 3;
  localparam int unsigned TMV_DW = 8;
  localparam int unsigned TMV_PW = 7;
  // register indices on the register port
  localparam logic [2:0] OFS_CNT = 3'h0;
  localparam logic [2:0] OFS_CORA = 3'h1;
  localparam logic [2:0] OFS_CORB = 3'h2;
  localparam logic [2:0] OFS_CTL0 = 3'h3;
  localparam logic [2:0] OFS_CSR = 3'h4;
  localparam logic [2:0] OFS_CTL1 = 3'h5;
  // reset values and counter maximum
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] COR_RST = 8'hFF;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] RD_IDLE = 8'h00;
  localparam logic [6:0] PRE_RST = 7'h00;
  // control zero fields
  localparam int unsigned C0_IE_B = 7;
  localparam int unsigned C0_IE_A = 6;
  localparam int unsigned C0_IE_W = 5;
  localparam int unsigned C0_CLR_HI = 4;
  localparam int unsigned C0_CLR_LO = 3;
  localparam int unsigned C0_CKS_HI = 2;
  localparam int unsigned C0_CKS_LO = 0;
  // control/status fields, bit 4 reads as one
  localparam int unsigned CS_FLAG_B = 7;
  localparam int unsigned CS_FLAG_A = 6;
  localparam int unsigned CS_FLAG_W = 5;
  localparam int unsigned CS_ACT_B_HI = 3;
  localparam int unsigned CS_ACT_B_LO = 2;
  localparam int unsigned CS_ACT_A_HI = 1;
  localparam int unsigned CS_ACT_A_LO = 0;
  localparam logic [7:0] CS_ONES = 8'h10;
  // control one fields, bits 7:5 and 1 read as one
  localparam int unsigned C1_EDGE_HI = 4;
  localparam int unsigned C1_EDGE_LO = 3;
  localparam int unsigned C1_TRIGGER_START_ENABLE = 2;
  localparam int unsigned C1_PICK = 0;
  localparam logic [7:0] C1_ONES = 8'hE2;
  // counter clear conditions
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_MATCH_A = 2'b01,
    CLR_MATCH_B = 2'b10,
    CLR_PIN = 2'b11
  } tmv_clr_t;
  // waveform pin action on a compare match
  typedef enum logic [1:0] {
    ACT_KEEP = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } tmv_act_t;
  // count gate state under trigger start
  typedef enum logic {
    ST_HALT = 1'b0,
    ST_RUN = 1'b1
  } tmv_run_t;
  // edge selection codes
  localparam logic [1:0] EDGE_RISE = 2'b01;
endpackage
`default_nettype wire

// ### tb/testbench.sv
// self-checking testbench of the eight-bit event timer
`default_nettype none
module testbench
  import tmv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset_n, ce, wr, rd, ext_clk, ext_clr, trig, wave, irq;
  logic [TMV_AW-1:0] addr;
  logic [TMV_DW-1:0] wdata, rdata, d;
  int mismatches = 0;
  int samples_checked = 0;

  tmv_timer u_tmv_timer (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_count_clock_pin_i(ext_clk), .ext_clear_pin_i(ext_clr),
    .start_trigger_pin_i(trig), .wave_out_pin_o(wave), .irq_o(irq));
  tmv_pins_model u_tmv_pins_model (.sys_clk_i(sys_clk), .ext_count_clock_pin_o(ext_clk),
    .ext_clear_pin_o(ext_clr), .start_trigger_pin_o(trig));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare, verdict, bus cycles
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    reg_rd(a, v);
    check($sformatf("reg%0d", a), v, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [7:0] exp [7];
    exp = '{CNT_RST, COR_RST, COR_RST, CTL_RST, CS_ONES, C1_ONES, RD_IDLE};
    for (int i = 0; i < 7; i++) rdchk(3'(i), exp[i]);
    check("wave", {7'h00, wave}, 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
  endtask
  task automatic t_regs();
    reg_wr(OFS_CORA, 8'h03);
    reg_wr(OFS_CORB, 8'h80);
    rdchk(OFS_CORA, 8'h03);
    rdchk(OFS_CORB, 8'h80);
    reg_wr(OFS_CNT, 8'h5A);
    rdchk(OFS_CNT, 8'h5A);
    @(posedge sys_clk);
    ce <= 1'b0;
    reg_wr(OFS_CORA, 8'h77);
    ce <= 1'b1;
    rdchk(OFS_CORA, 8'h03);
  endtask
  // external rise, fall, both edges
  task automatic t_ext();
    for (int i = 5; i < 8; i++) begin
      reg_wr(OFS_CTL0, 8'(i));
      reg_wr(OFS_CNT, 8'h00);
      u_tmv_pins_model.pulse(0, 2);
      idle(6);
      rdchk(OFS_CNT, (i == 7) ? 8'h04 : 8'h02);
    end
  endtask
  // match A clears counter, sets flag, toggles pin, raises irq
  task automatic t_match_a();
    rdchk(OFS_CSR, 8'h50);
    reg_wr(OFS_CSR, 8'h03);
    reg_wr(OFS_CNT, 8'h00);
    reg_wr(OFS_CTL0, 8'h4D);
    u_tmv_pins_model.pulse(0, 3);
    idle(6);
    check("wave", {7'h00, wave}, 8'h01);
    check("irq", {7'h00, irq}, 8'h01);
    rdchk(OFS_CNT, 8'h00);
    rdchk(OFS_CSR, 8'h53);
    reg_wr(OFS_CSR, 8'h03);
    idle(3);
    check("irq", {7'h00, irq}, 8'h00);
    rdchk(OFS_CSR, 8'h13);
  endtask
  task automatic t_wrap();
    reg_wr(OFS_CTL0, 8'h25);
    reg_wr(OFS_CNT, 8'hFF);
    u_tmv_pins_model.pulse(0, 1);
    idle(6);
    check("irq", {7'h00, irq}, 8'h01);
    check("wave", {7'h00, wave}, 8'h01);
    rdchk(OFS_CNT, 8'h00);
    rdchk(OFS_CSR, 8'h33);
    reg_wr(OFS_CSR, 8'h03);
  endtask
  task automatic t_presc();
    for (int p = 0; p < 2; p++) begin
      reg_wr(OFS_CTL1, 8'(p));
      reg_wr(OFS_CTL0, 8'h01);
      reg_wr(OFS_CNT, 8'h00);
      idle(40 << p);
      reg_rd(OFS_CNT, d);
      check("presc", {7'h00, d inside {[8'h09:8'h0B]}}, 8'h01);
    end
    for (int c = 0; c < 2; c++) begin
      reg_wr(OFS_CTL0, c ? 8'h04 : 8'h00);
      reg_rd(OFS_CNT, d);
      idle(40);
      rdchk(OFS_CNT, d);
    end
  endtask
  task automatic t_pins();
    reg_wr(OFS_CTL1, 8'h00);
    reg_wr(OFS_CTL0, 8'h1D);
    reg_wr(OFS_CNT, 8'h20);
    u_tmv_pins_model.pulse(1, 1);
    idle(6);
    rdchk(OFS_CNT, 8'h00);
    reg_wr(OFS_CTL1, 8'h0C);
    u_tmv_pins_model.pulse(1, 1);
    u_tmv_pins_model.pulse(0, 2);
    idle(6);
    rdchk(OFS_CNT, 8'h00);
    u_tmv_pins_model.pulse(2, 1);
    u_tmv_pins_model.pulse(0, 2);
    idle(6);
    rdchk(OFS_CNT, 8'h02);
  endtask
  task automatic t_match_b();
    reg_wr(OFS_CTL1, 8'h00);
    reg_wr(OFS_CORB, 8'h02);
    reg_wr(OFS_CTL0, 8'h15);
    reg_wr(OFS_CNT, 8'h00);
    u_tmv_pins_model.pulse(0, 2);
    idle(6);
    rdchk(OFS_CNT, 8'h00);
    rdchk(OFS_CSR, 8'hD3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and hang guard
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_ext();
    t_match_a();
    t_wrap();
    t_presc();
    t_pins();
    t_match_b();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire

// ### tb/tmv_pins_model.sv
// pin source model for the event timer: count clock, clear and trigger
`default_nettype none
module tmv_pins_model (
  input wire logic sys_clk_i,
  output logic ext_count_clock_pin_o,
  output logic ext_clear_pin_o,
  output logic start_trigger_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] pins_q = 3'h0;

  // driven levels, the lines are never released
  assign ext_count_clock_pin_o = pins_q[0];
  assign ext_clear_pin_o = pins_q[1];
  assign start_trigger_pin_o = pins_q[2];

  // n pulses on one pin, two cycles high and two low so the synchroniser sees each level
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      repeat (2) @(posedge sys_clk_i);
      pins_q[sel] <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      pins_q[sel] <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire
